// [src/cbe_pkg.sv]
package cbe_pkg;

	// operation codes handed over by the fetch/decode stage
	typedef enum logic [4:0] {
		CBE_OP_NOP   = 5'h00,
		CBE_OP_RRC   = 5'h01,
		CBE_OP_SRA   = 5'h02,
		CBE_OP_SWAP  = 5'h03,
		CBE_OP_BSET  = 5'h04,
		CBE_OP_BCLR  = 5'h05,
		CBE_OP_TSAVE = 5'h06,
		CBE_OP_TLOAD = 5'h07,
		CBE_OP_MOV   = 5'h08,
		CBE_OP_PAIR  = 5'h09,
		CBE_OP_LDI   = 5'h0A,
		CBE_OP_LDPTR = 5'h0B,
		CBE_OP_LDDSP = 5'h0C,
		CBE_OP_LDABS = 5'h0D,
		CBE_OP_STPTR = 5'h0E,
		CBE_OP_STDSP = 5'h0F,
		CBE_OP_STABS = 5'h10,
		CBE_OP_PMRD  = 5'h11,
		CBE_OP_IN    = 5'h12,
		CBE_OP_OUT   = 5'h13,
		CBE_OP_PUSH  = 5'h14,
		CBE_OP_POP   = 5'h15,
		CBE_OP_SLEEP = 5'h16,
		CBE_OP_WDOG  = 5'h17,
		CBE_OP_BREAK = 5'h18,
		CBE_OP_PMWR  = 5'h19
	} cbe_op_type;

	typedef enum logic [1:0] {
		CBE_PTR_X = 2'h0,
		CBE_PTR_Y = 2'h1,
		CBE_PTR_Z = 2'h2
	} cbe_ptr_type;

	typedef enum logic [1:0] {
		CBE_MODE_PLAIN   = 2'h0,
		CBE_MODE_POSTINC = 2'h1,
		CBE_MODE_PREDEC  = 2'h2
	} cbe_mode_type;

	// gray coded along idle -> second -> third cycle
	typedef enum logic [1:0] {
		CBE_ST_IDLE  = 2'b00,
		CBE_ST_CYC2  = 2'b01,
		CBE_ST_CYC3  = 2'b11
	} cbe_state_type;

	// flag positions inside status_flags_reg
	localparam int unsigned CBE_FLAG_C = 0;
	localparam int unsigned CBE_FLAG_Z = 1;
	localparam int unsigned CBE_FLAG_N = 2;
	localparam int unsigned CBE_FLAG_V = 3;
	localparam int unsigned CBE_FLAG_S = 4;
	localparam int unsigned CBE_FLAG_H = 5;
	localparam int unsigned CBE_FLAG_T = 6;
	localparam int unsigned CBE_FLAG_I = 7;

	// low register of each pointer pair
	localparam logic [4:0] CBE_X_LO = 5'h1A;
	localparam logic [4:0] CBE_Y_LO = 5'h1C;
	localparam logic [4:0] CBE_Z_LO = 5'h1E;

	localparam logic [7:0]  CBE_FLAGS_RESET = 8'h00;
	localparam logic [7:0]  CBE_REG_RESET   = 8'h00;
	localparam logic [15:0] CBE_SP_RESET    = 16'h00FF;
	localparam logic [15:0] CBE_ADDR_ONE    = 16'h0001;

	// cycles per instruction class
	localparam int unsigned CBE_CYC_SIMPLE = 1;
	localparam int unsigned CBE_CYC_DMEM   = 2;
	localparam int unsigned CBE_CYC_PMEM   = 3;

endpackage

// [src/cbe_bitop_if.sv]
`timescale 1ns/1ps
interface cbe_bitop_if;
	cbe_pkg::cbe_op_type op;
	logic [7:0]          operand;
	logic [2:0]          bit_sel;
	logic [7:0]          flags_in;
	logic [7:0]          result;
	logic [7:0]          flags_out;

	modport core (output op, output operand, output bit_sel, output flags_in, input result, input flags_out);
	modport unit (input op, input operand, input bit_sel, input flags_in, output result, output flags_out);
endinterface

// [src/cbe_bitop_unit.sv]
`timescale 1ns/1ps
module cbe_bitop_unit (
	cbe_bitop_if.unit bus
);
	logic [7:0] rrc_val;
	logic [7:0] sra_val;
	logic [7:0] swap_val;
	logic [7:0] tload_val;
	logic [7:0] shift_val;
	logic [7:0] shift_flags;
	logic       shift_n;
	logic       shift_c;
	logic       is_shift;

	assign rrc_val   = {bus.flags_in[cbe_pkg::CBE_FLAG_C], bus.operand[7:1]};
	assign sra_val   = {bus.operand[7], bus.operand[7:1]};
	assign swap_val  = {bus.operand[3:0], bus.operand[7:4]};
	assign is_shift  = (bus.op == cbe_pkg::CBE_OP_RRC) || (bus.op == cbe_pkg::CBE_OP_SRA);
	assign shift_val = (bus.op == cbe_pkg::CBE_OP_RRC) ? rrc_val : sra_val;
	assign shift_c   = bus.operand[0];
	assign shift_n   = shift_val[7];

	// only z, c, n and v move on a shift; the sign flag is left alone
	always_comb begin
		shift_flags = bus.flags_in;
		shift_flags[cbe_pkg::CBE_FLAG_C] = shift_c;
		shift_flags[cbe_pkg::CBE_FLAG_Z] = (shift_val == 8'h00);
		shift_flags[cbe_pkg::CBE_FLAG_N] = shift_n;
		shift_flags[cbe_pkg::CBE_FLAG_V] = shift_n ^ shift_c;
	end

	always_comb begin
		tload_val = bus.operand;
		tload_val[bus.bit_sel] = bus.flags_in[cbe_pkg::CBE_FLAG_T];
	end

	always_comb begin
		bus.result    = bus.operand;
		bus.flags_out = bus.flags_in;
		if (is_shift) begin
			bus.result    = shift_val;
			bus.flags_out = shift_flags;
		end else if (bus.op == cbe_pkg::CBE_OP_SWAP) begin
			bus.result = swap_val;
		end else if (bus.op == cbe_pkg::CBE_OP_TLOAD) begin
			bus.result = tload_val;
		end else if (bus.op == cbe_pkg::CBE_OP_TSAVE) begin
			bus.flags_out[cbe_pkg::CBE_FLAG_T] = bus.operand[bus.bit_sel];
		end
	end
endmodule

// [src/cbe_exec.sv]
`timescale 1ns/1ps
module cbe_exec (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic                 issue_valid,
	input  wire cbe_pkg::cbe_op_type  issue_op,
	input  wire logic [4:0]           dst_idx,
	input  wire logic [4:0]           src_idx,
	input  wire logic [2:0]           bit_sel,
	input  wire logic [7:0]           imm_data,
	input  wire logic [5:0]           disp,
	input  wire logic [15:0]          abs_addr,
	input  wire cbe_pkg::cbe_ptr_type ptr_sel,
	input  wire cbe_pkg::cbe_mode_type ptr_mode,
	input  wire logic [5:0]           io_addr,
	input  wire logic [7:0]           io_rdata,
	input  wire logic [7:0]           dmem_rdata,
	input  wire logic [7:0]           pmem_rdata,
	input  wire logic [4:0]           view_idx,
	output logic                      issue_ready,
	output logic                      done,
	output logic [15:0]               dmem_addr,
	output logic [7:0]                dmem_wdata,
	output logic                      dmem_we,
	output logic                      dmem_re,
	output logic [15:0]               pmem_addr,
	output logic                      pmem_re,
	output logic [5:0]                io_addr_out,
	output logic [7:0]                io_wdata,
	output logic                      io_we,
	output logic                      sleep_req,
	output logic                      watchdog_restart_op,
	output logic                      break_req,
	output logic                      program_mem_write,
	output logic [7:0]                status_flags,
	output logic [15:0]               stack_ptr,
	output logic [7:0]                view_data
);
	logic [7:0]             rf_reg [32];
	logic [7:0]             status_flags_reg;
	logic [15:0]            sp_reg;
	cbe_pkg::cbe_state_type state_reg;
	cbe_pkg::cbe_state_type state_next;
	logic [4:0]             load_idx_reg;
	logic                   is_load_reg;
	logic                   done_reg;
	logic                   ready_reg;
	logic [15:0]            dmem_addr_reg;
	logic [7:0]             dmem_wdata_reg;
	logic                   dmem_we_reg;
	logic                   dmem_re_reg;
	logic [15:0]            pmem_addr_reg;
	logic                   pmem_re_reg;
	logic [5:0]             io_addr_reg;
	logic [7:0]             io_wdata_reg;
	logic                   io_we_reg;
	logic                   sleep_reg;
	logic                   wdog_reg;
	logic                   break_reg;
	logic                   pmwr_reg;
	logic [7:0]             view_reg;

	cbe_bitop_if bop ();

	cbe_bitop_unit u_bitop (
		.bus (bop.unit)
	);

	// gating on ready keeps the first edge after reset from taking an op
	wire        take      = issue_valid && ready_reg && (state_reg == cbe_pkg::CBE_ST_IDLE);
	wire [4:0]  ptr_lo    = (ptr_sel == cbe_pkg::CBE_PTR_X) ? cbe_pkg::CBE_X_LO :
	                        (ptr_sel == cbe_pkg::CBE_PTR_Y) ? cbe_pkg::CBE_Y_LO : cbe_pkg::CBE_Z_LO;
	wire [4:0]  ptr_hi    = ptr_lo | 5'h01;
	wire [15:0] ptr_val   = {rf_reg[ptr_hi], rf_reg[ptr_lo]};
	wire [15:0] ptr_inc   = ptr_val + cbe_pkg::CBE_ADDR_ONE;
	wire [15:0] ptr_dec   = ptr_val - cbe_pkg::CBE_ADDR_ONE;
	wire [15:0] ptr_disp  = ptr_val + {10'h000, disp};
	wire [15:0] sp_inc    = sp_reg + cbe_pkg::CBE_ADDR_ONE;
	wire [15:0] sp_dec    = sp_reg - cbe_pkg::CBE_ADDR_ONE;
	wire        is_ld_ptr = (issue_op == cbe_pkg::CBE_OP_LDPTR);
	wire        is_st_ptr = (issue_op == cbe_pkg::CBE_OP_STPTR);
	wire        is_pmrd   = (issue_op == cbe_pkg::CBE_OP_PMRD);
	wire        is_dload  = is_ld_ptr || (issue_op == cbe_pkg::CBE_OP_LDDSP) ||
	                        (issue_op == cbe_pkg::CBE_OP_LDABS) || (issue_op == cbe_pkg::CBE_OP_POP);
	wire        is_dstore = is_st_ptr || (issue_op == cbe_pkg::CBE_OP_STDSP) ||
	                        (issue_op == cbe_pkg::CBE_OP_STABS) || (issue_op == cbe_pkg::CBE_OP_PUSH);
	wire        is_bitop  = (issue_op == cbe_pkg::CBE_OP_RRC) || (issue_op == cbe_pkg::CBE_OP_SRA) ||
	                        (issue_op == cbe_pkg::CBE_OP_SWAP) || (issue_op == cbe_pkg::CBE_OP_TLOAD);
	wire        ptr_post  = (is_ld_ptr || is_st_ptr) && (ptr_mode == cbe_pkg::CBE_MODE_POSTINC);
	wire        ptr_pre   = (is_ld_ptr || is_st_ptr) && (ptr_mode == cbe_pkg::CBE_MODE_PREDEC);
	// program read post-increment always walks z whatever ptr_sel says
	wire        pmrd_post = is_pmrd && (ptr_mode == cbe_pkg::CBE_MODE_POSTINC);
	wire [15:0] z_val     = {rf_reg[cbe_pkg::CBE_Z_LO | 5'h01], rf_reg[cbe_pkg::CBE_Z_LO]};
	wire [15:0] z_inc     = z_val + cbe_pkg::CBE_ADDR_ONE;

	// address of the data memory access, per addressing form
	wire [15:0] dm_addr =
		ptr_pre                                ? ptr_dec :
		(is_ld_ptr || is_st_ptr)               ? ptr_val :
		(issue_op == cbe_pkg::CBE_OP_LDDSP ||
		 issue_op == cbe_pkg::CBE_OP_STDSP)    ? ptr_disp :
		(issue_op == cbe_pkg::CBE_OP_PUSH)     ? sp_reg :
		(issue_op == cbe_pkg::CBE_OP_POP)      ? sp_inc :
		abs_addr;

	assign bop.op       = issue_op;
	assign bop.operand  = (issue_op == cbe_pkg::CBE_OP_TSAVE) ? rf_reg[src_idx] : rf_reg[dst_idx];
	assign bop.bit_sel  = bit_sel;
	assign bop.flags_in = status_flags_reg;

	// next state decides how many cycles the taken operation occupies
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cbe_pkg::CBE_ST_IDLE: begin
				if (take && (is_dload || is_dstore || is_pmrd))
					state_next = cbe_pkg::CBE_ST_CYC2;
			end
			cbe_pkg::CBE_ST_CYC2: begin
				state_next = is_load_reg && pmem_re_reg ? cbe_pkg::CBE_ST_CYC3 : cbe_pkg::CBE_ST_IDLE;
			end
			cbe_pkg::CBE_ST_CYC3: begin
				state_next = cbe_pkg::CBE_ST_IDLE;
			end
			default: state_next = cbe_pkg::CBE_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= cbe_pkg::CBE_ST_IDLE;
			ready_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			ready_reg <= (state_next == cbe_pkg::CBE_ST_IDLE);
			done_reg  <= (take && state_next == cbe_pkg::CBE_ST_IDLE) ||
			             (state_reg != cbe_pkg::CBE_ST_IDLE && state_next == cbe_pkg::CBE_ST_IDLE);
		end
	end

	// memory and port strobes launched at the taking edge: one-cycle pulses, except pmem_re which is held for two cycles
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dmem_addr_reg  <= 16'h0000;
			dmem_wdata_reg <= 8'h00;
			dmem_we_reg    <= 1'b0;
			dmem_re_reg    <= 1'b0;
			pmem_addr_reg  <= 16'h0000;
			pmem_re_reg    <= 1'b0;
			io_addr_reg    <= 6'h00;
			io_wdata_reg   <= 8'h00;
			io_we_reg      <= 1'b0;
			sleep_reg      <= 1'b0;
			wdog_reg       <= 1'b0;
			break_reg      <= 1'b0;
			pmwr_reg       <= 1'b0;
			load_idx_reg   <= 5'h00;
			is_load_reg    <= 1'b0;
		end else begin
			dmem_we_reg <= take && is_dstore;
			dmem_re_reg <= take && is_dload;
			io_we_reg   <= take && (issue_op == cbe_pkg::CBE_OP_OUT);
			sleep_reg   <= take && (issue_op == cbe_pkg::CBE_OP_SLEEP);
			wdog_reg    <= take && (issue_op == cbe_pkg::CBE_OP_WDOG);
			break_reg   <= take && (issue_op == cbe_pkg::CBE_OP_BREAK);
			pmwr_reg    <= take && (issue_op == cbe_pkg::CBE_OP_PMWR);
			if (take) begin
				pmem_re_reg  <= is_pmrd;
				is_load_reg  <= is_dload || is_pmrd;
				load_idx_reg <= dst_idx;
			end else if (state_reg == cbe_pkg::CBE_ST_CYC3) begin
				pmem_re_reg <= 1'b0;
			end
			if (take && (is_dload || is_dstore)) begin
				dmem_addr_reg  <= dm_addr;
				dmem_wdata_reg <= rf_reg[src_idx];
			end
			if (take && is_pmrd)
				pmem_addr_reg <= z_val;
			if (take && issue_op == cbe_pkg::CBE_OP_OUT) begin
				io_addr_reg  <= io_addr;
				io_wdata_reg <= rf_reg[src_idx];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_flags_reg <= cbe_pkg::CBE_FLAGS_RESET;
			sp_reg           <= cbe_pkg::CBE_SP_RESET;
		end else if (take) begin
			if (is_bitop || issue_op == cbe_pkg::CBE_OP_TSAVE)
				status_flags_reg <= bop.flags_out;
			else if (issue_op == cbe_pkg::CBE_OP_BSET)
				status_flags_reg[bit_sel] <= 1'b1;
			else if (issue_op == cbe_pkg::CBE_OP_BCLR)
				status_flags_reg[bit_sel] <= 1'b0;
			if (issue_op == cbe_pkg::CBE_OP_PUSH)
				sp_reg <= sp_dec;
			else if (issue_op == cbe_pkg::CBE_OP_POP)
				sp_reg <= sp_inc;
		end
	end

	// register file; a load landing later wins over a pointer update to the same register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++)
				rf_reg[i] <= cbe_pkg::CBE_REG_RESET;
		end else if (take) begin
			if (is_bitop)
				rf_reg[dst_idx] <= bop.result;
			else if (issue_op == cbe_pkg::CBE_OP_MOV)
				rf_reg[dst_idx] <= rf_reg[src_idx];
			else if (issue_op == cbe_pkg::CBE_OP_PAIR) begin
				rf_reg[dst_idx & 5'h1E] <= rf_reg[src_idx & 5'h1E];
				rf_reg[dst_idx | 5'h01] <= rf_reg[src_idx | 5'h01];
			end else if (issue_op == cbe_pkg::CBE_OP_LDI)
				rf_reg[dst_idx] <= imm_data;
			else if (issue_op == cbe_pkg::CBE_OP_IN)
				rf_reg[dst_idx] <= io_rdata;
			if (ptr_post) begin
				rf_reg[ptr_lo] <= ptr_inc[7:0];
				rf_reg[ptr_hi] <= ptr_inc[15:8];
			end else if (ptr_pre) begin
				rf_reg[ptr_lo] <= ptr_dec[7:0];
				rf_reg[ptr_hi] <= ptr_dec[15:8];
			end else if (pmrd_post) begin
				rf_reg[cbe_pkg::CBE_Z_LO]         <= z_inc[7:0];
				rf_reg[cbe_pkg::CBE_Z_LO | 5'h01] <= z_inc[15:8];
			end
		end else if (state_reg == cbe_pkg::CBE_ST_CYC2 && is_load_reg && !pmem_re_reg) begin
			rf_reg[load_idx_reg] <= dmem_rdata;
		end else if (state_reg == cbe_pkg::CBE_ST_CYC3) begin
			rf_reg[load_idx_reg] <= pmem_rdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			view_reg <= 8'h00;
		else
			view_reg <= rf_reg[view_idx];
	end

	assign issue_ready         = ready_reg;
	assign done                = done_reg;
	assign dmem_addr           = dmem_addr_reg;
	assign dmem_wdata          = dmem_wdata_reg;
	assign dmem_we             = dmem_we_reg;
	assign dmem_re             = dmem_re_reg;
	assign pmem_addr           = pmem_addr_reg;
	assign pmem_re             = pmem_re_reg;
	assign io_addr_out         = io_addr_reg;
	assign io_wdata            = io_wdata_reg;
	assign io_we               = io_we_reg;
	assign sleep_req           = sleep_reg;
	assign watchdog_restart_op = wdog_reg;
	assign break_req           = break_reg;
	assign program_mem_write   = pmwr_reg;
	assign status_flags        = status_flags_reg;
	assign stack_ptr           = sp_reg;
	assign view_data           = view_reg;
endmodule

// [bench/cbe_mem_model.sv]
`timescale 1ns/1ps
module cbe_mem_model (
	input  wire logic        mclk,
	input  wire logic [15:0] dmem_addr,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we,
	input  wire logic        dmem_re,
	input  wire logic [15:0] pmem_addr,
	input  wire logic        pmem_re,
	output logic [7:0]       dmem_rdata,
	output logic [7:0]       pmem_rdata
);
	logic [7:0] mem [0:255];
	logic [7:0] last_reg    = 8'h00;
	logic       pmem_ok_reg = 1'b0;
	// released lines show the inverse of the last byte, so a late sample cannot pass
	assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~last_reg;
	// program byte is a pure function of the address and is ready only from the second read cycle
	assign pmem_rdata = (pmem_re && pmem_ok_reg) ? (pmem_addr[15:8] ^ pmem_addr[7:0]) : ~last_reg;
	always @(posedge mclk) begin
		if (dmem_we) begin
			mem[dmem_addr[7:0]] <= dmem_wdata;
		end
		if (dmem_re) begin
			last_reg <= dmem_rdata;
		end
		pmem_ok_reg <= pmem_re;
	end
endmodule

// [bench/cbe_exec_properties.sv]
`timescale 1ns/1ps
module cbe_exec_checker (
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                issue_valid,
	input wire logic                issue_ready,
	input wire cbe_pkg::cbe_op_type issue_op,
	input wire logic [2:0]          bit_sel,
	input wire logic [15:0]         abs_addr,
	input wire logic                done,
	input wire logic [15:0]         dmem_addr,
	input wire logic                dmem_we,
	input wire logic                dmem_re,
	input wire logic                pmem_re,
	input wire logic [7:0]          status_flags,
	input wire logic [15:0]         stack_ptr
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	wire taken = issue_valid && issue_ready;
	property p_rrc;
		taken && issue_op == cbe_pkg::CBE_OP_RRC |=> done ##1 !done;
	endproperty
	a_rrc: assert property (p_rrc) else $error("rotate not done in one cycle");
	property p_swap;
		taken && issue_op == cbe_pkg::CBE_OP_SWAP |=> done && $stable(status_flags);
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap touched flags");
	property p_tsave;
		taken && issue_op == cbe_pkg::CBE_OP_TSAVE |=> done && ((status_flags ^ $past(status_flags)) & 8'hBF) == 8'h00;
	endproperty
	a_tsave: assert property (p_tsave) else $error("bit copy changed a flag other than transfer");
	property p_bset;
		taken && issue_op == cbe_pkg::CBE_OP_BSET |=> status_flags == ($past(status_flags) | (8'h01 << $past(bit_sel)));
	endproperty
	a_bset: assert property (p_bset) else $error("flag set wrong");
	property p_ldptr;
		taken && issue_op == cbe_pkg::CBE_OP_LDPTR |=> dmem_re && !done ##1 done && !dmem_re;
	endproperty
	a_ldptr: assert property (p_ldptr) else $error("pointer load timing wrong");
	property p_stabs;
		taken && issue_op == cbe_pkg::CBE_OP_STABS |=> dmem_we && dmem_addr == $past(abs_addr) ##1 done;
	endproperty
	a_stabs: assert property (p_stabs) else $error("direct store address or timing wrong");
	property p_pmrd;
		taken && issue_op == cbe_pkg::CBE_OP_PMRD |=> (pmem_re && !done) [*2] ##1 done;
	endproperty
	a_pmrd: assert property (p_pmrd) else $error("program read not three cycles");
	property p_push;
		taken && issue_op == cbe_pkg::CBE_OP_PUSH |=> dmem_we && dmem_addr == $past(stack_ptr)
			&& stack_ptr == $past(stack_ptr) - 16'h0001 ##1 done;
	endproperty
	a_push: assert property (p_push) else $error("push address or stack pointer wrong");
endmodule
bind cbe_exec cbe_exec_checker chk_u (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .issue_ready(issue_ready),
	.issue_op(issue_op), .bit_sel(bit_sel), .abs_addr(abs_addr), .done(done), .dmem_addr(dmem_addr),
	.dmem_we(dmem_we), .dmem_re(dmem_re), .pmem_re(pmem_re), .status_flags(status_flags), .stack_ptr(stack_ptr));

// [bench/cpu_bitop_load_store_exec_tb.sv]
`timescale 1ns/1ps
module cpu_bitop_load_store_exec_tb;
	logic                  mclk, done, issue_ready, dmem_we, dmem_re, pmem_re, io_we, sleep_req;
	logic                  watchdog_restart_op, break_req, program_mem_write;
	logic                  rst_n = 1'b0;
	logic                  issue_valid = 1'b0;
	cbe_pkg::cbe_op_type   issue_op = cbe_pkg::CBE_OP_NOP;
	cbe_pkg::cbe_ptr_type  ptr_sel = cbe_pkg::CBE_PTR_X;
	cbe_pkg::cbe_mode_type ptr_mode = cbe_pkg::CBE_MODE_PLAIN;
	logic [4:0]            dst_idx = 5'h00, src_idx = 5'h00, view_idx = 5'h00, strb;
	logic [2:0]            bit_sel = 3'h0;
	logic [5:0]            disp = 6'h00, io_addr = 6'h00, io_addr_out;
	logic [7:0]            imm_data = 8'h00, io_rdata = 8'h00, dmem_rdata, pmem_rdata, dmem_wdata, io_wdata;
	logic [7:0]            status_flags, view_data;
	logic [15:0]           abs_addr = 16'h0000, dmem_addr, pmem_addr, stack_ptr;
	int                    mismatches = 0, n_checks = 0;
	cbe_exec dut_u (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .issue_op(issue_op), .dst_idx(dst_idx),
		.src_idx(src_idx), .bit_sel(bit_sel), .imm_data(imm_data), .disp(disp), .abs_addr(abs_addr), .ptr_sel(ptr_sel),
		.ptr_mode(ptr_mode), .io_addr(io_addr), .io_rdata(io_rdata), .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata),
		.view_idx(view_idx), .issue_ready(issue_ready), .done(done), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
		.dmem_we(dmem_we), .dmem_re(dmem_re), .pmem_addr(pmem_addr), .pmem_re(pmem_re), .io_addr_out(io_addr_out),
		.io_wdata(io_wdata), .io_we(io_we), .sleep_req(sleep_req), .watchdog_restart_op(watchdog_restart_op),
		.break_req(break_req), .program_mem_write(program_mem_write), .status_flags(status_flags),
		.stack_ptr(stack_ptr), .view_data(view_data));
	cbe_mem_model mem_u (.mclk(mclk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
		.dmem_re(dmem_re), .pmem_addr(pmem_addr), .pmem_re(pmem_re), .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// offer one op at an edge, then count cycles up to the done pulse
	task automatic run(input cbe_pkg::cbe_op_type op, input logic [4:0] d, input logic [4:0] s, input int n);
		int c;
		issue_op <= op;
		dst_idx <= d;
		src_idx <= s;
		issue_valid <= 1'b1;
		@(posedge mclk);
		issue_valid <= 1'b0;
		c = 1;
		#1;
		while (done !== 1'b1 && c < 9) begin
			@(posedge mclk);
			#1;
			c++;
		end
		strb = {sleep_req, watchdog_restart_op, break_req, program_mem_write, io_we};
		chk(16'(c), 16'(n), "cycle count");
		@(posedge mclk);
	endtask
	task automatic peek(input logic [4:0] r, input logic [7:0] e);
		view_idx <= r;
		repeat (2) @(posedge mclk);
		#1;
		chk(16'(view_data), 16'(e), "register");
		@(posedge mclk);
	endtask
	task automatic ldi(input logic [4:0] r, input logic [7:0] v);
		imm_data <= v;
		run(cbe_pkg::CBE_OP_LDI, r, 5'h00, 1);
	endtask
	task automatic t_shift;
		ldi(5'h10, 8'h81);
		ldi(5'h11, 8'h81);
		run(cbe_pkg::CBE_OP_RRC, 5'h10, 5'h00, 1);
		chk(16'(status_flags), 16'h0009, "rotate flags");
		run(cbe_pkg::CBE_OP_RRC, 5'h10, 5'h00, 1);
		chk(16'(status_flags), 16'h000C, "rotate carry in");
		peek(5'h10, 8'hA0);
		run(cbe_pkg::CBE_OP_SRA, 5'h11, 5'h00, 1);
		chk(16'(status_flags), 16'h0005, "shift flags");
		peek(5'h11, 8'hC0);
		$display("shift test done");
	endtask
	task automatic t_bits;
		logic [7:0] f;
		run(cbe_pkg::CBE_OP_SWAP, 5'h10, 5'h00, 1);
		peek(5'h10, 8'h0A);
		bit_sel <= 3'h3;
		run(cbe_pkg::CBE_OP_TSAVE, 5'h00, 5'h10, 1);
		chk(16'(status_flags), 16'h0045, "transfer flag");
		bit_sel <= 3'h6;
		run(cbe_pkg::CBE_OP_TLOAD, 5'h12, 5'h00, 1);
		peek(5'h12, 8'h40);
		f = 8'h45;
		for (int i = 0; i < 8; i++) begin
			bit_sel <= 3'(i);
			run(cbe_pkg::CBE_OP_BSET, 5'h00, 5'h00, 1);
			f = f | (8'h01 << i);
			chk(16'(status_flags), 16'(f), "flag set");
			run(cbe_pkg::CBE_OP_BCLR, 5'h00, 5'h00, 1);
			f = f & ~(8'h01 << i);
			chk(16'(status_flags), 16'(f), "flag clear");
		end
		$display("bit test done");
	endtask
	task automatic t_mem;
		ldi(5'h1A, 8'h10);
		ptr_mode <= cbe_pkg::CBE_MODE_POSTINC;
		run(cbe_pkg::CBE_OP_LDPTR, 5'h14, 5'h00, 2);
		peek(5'h1A, 8'h11);
		ptr_mode <= cbe_pkg::CBE_MODE_PREDEC;
		run(cbe_pkg::CBE_OP_LDPTR, 5'h15, 5'h00, 2);
		peek(5'h15, 8'h3C);
		run(cbe_pkg::CBE_OP_STPTR, 5'h00, 5'h12, 2);
		chk(16'(mem_u.mem[8'h0F]), 16'h0040, "predec store");
		ptr_mode <= cbe_pkg::CBE_MODE_POSTINC;
		run(cbe_pkg::CBE_OP_STPTR, 5'h00, 5'h10, 2);
		chk(16'(mem_u.mem[8'h0F]), 16'h000A, "postinc store");
		peek(5'h1A, 8'h10);
		ldi(5'h1C, 8'h20);
		ptr_sel <= cbe_pkg::CBE_PTR_Y;
		disp <= 6'h05;
		run(cbe_pkg::CBE_OP_LDDSP, 5'h16, 5'h00, 2);
		peek(5'h16, 8'h77);
		disp <= 6'h3F;
		run(cbe_pkg::CBE_OP_STDSP, 5'h00, 5'h16, 2);
		chk(16'(mem_u.mem[8'h5F]), 16'h0077, "displaced store");
		peek(5'h1C, 8'h20);
		abs_addr <= 16'h0030;
		run(cbe_pkg::CBE_OP_LDABS, 5'h17, 5'h00, 2);
		peek(5'h17, 8'h99);
		abs_addr <= 16'h0031;
		run(cbe_pkg::CBE_OP_STABS, 5'h00, 5'h17, 2);
		chk(16'(mem_u.mem[8'h31]), 16'h0099, "direct store");
		run(cbe_pkg::CBE_OP_PUSH, 5'h00, 5'h17, 2);
		chk(16'(mem_u.mem[8'hFF]), 16'h0099, "push data");
		run(cbe_pkg::CBE_OP_POP, 5'h18, 5'h00, 2);
		chk(stack_ptr, 16'h00FF, "stack pointer");
		peek(5'h18, 8'h99);
		chk(16'(status_flags), 16'h0000, "flags after transfers");
		$display("data memory test done");
	endtask
	task automatic t_prog_ctrl;
		ldi(5'h1E, 8'h34);
		ldi(5'h1F, 8'h12);
		run(cbe_pkg::CBE_OP_PMRD, 5'h19, 5'h00, 3);
		peek(5'h19, 8'h26);
		ptr_mode <= cbe_pkg::CBE_MODE_PLAIN;
		run(cbe_pkg::CBE_OP_PMRD, 5'h00, 5'h00, 3);
		peek(5'h00, 8'h27);
		run(cbe_pkg::CBE_OP_SLEEP, 5'h00, 5'h00, 1);
		chk(16'(strb), 16'h0010, "sleep strobe");
		run(cbe_pkg::CBE_OP_WDOG, 5'h00, 5'h00, 1);
		chk(16'(strb), 16'h0008, "watchdog strobe");
		run(cbe_pkg::CBE_OP_BREAK, 5'h00, 5'h00, 1);
		chk(16'(strb), 16'h0004, "break strobe");
		run(cbe_pkg::CBE_OP_PMWR, 5'h00, 5'h00, 1);
		chk(16'(strb), 16'h0002, "program write strobe");
		run(cbe_pkg::CBE_OP_NOP, 5'h00, 5'h00, 1);
		chk(16'(strb), 16'h0000, "no-op strobes");
		run(cbe_pkg::CBE_OP_PAIR, 5'h02, 5'h18, 1);
		peek(5'h03, 8'h26);
		io_rdata <= 8'h5E;
		run(cbe_pkg::CBE_OP_IN, 5'h04, 5'h00, 1);
		io_addr <= 6'h2A;
		run(cbe_pkg::CBE_OP_OUT, 5'h00, 5'h04, 1);
		chk(16'({strb[0], 1'b0, io_addr_out, io_wdata}), 16'hAA5E, "port write");
		run(cbe_pkg::CBE_OP_MOV, 5'h05, 5'h04, 1);
		peek(5'h05, 8'h5E);
		chk(16'(status_flags), 16'h0000, "flags after control");
		$display("program and control test done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		mem_u.mem[8'h10] = 8'h3C;
		mem_u.mem[8'h25] = 8'h77;
		mem_u.mem[8'h30] = 8'h99;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_shift();
		t_bits();
		t_mem();
		t_prog_ctrl();
		tally_and_finish();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		tally_and_finish();
	end
endmodule
